/* File: common/tps_pkg.sv */
package tps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Task map
    localparam int NUM_TASKS = 48;
    localparam int NUM_FIX = 16;
    localparam int NUM_EXT = 8;
    localparam int NUM_INT = 16;
    localparam int NUM_HSC = 8;
    localparam logic [5:0] FIX_BASE = 6'h00;
    localparam logic [5:0] EXT_BASE = 6'h10;
    localparam logic [5:0] INT_BASE = 6'h18;
    localparam logic [5:0] HSC_BASE = 6'h28;
    localparam logic [5:0] LAST_TASK = 6'h2F;
    localparam logic [2:0] PRIO_MIN = 3'h2;
    localparam logic [2:0] PRIO_MAX = 3'h7;
    localparam int AGE_W = 16;
    localparam int CNT_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 1000000;
    localparam int MS_CYCLES = TICK_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_CMD = 8'h04;
    localparam logic [7:0] ADR_SEL = 8'h08;
    localparam logic [7:0] ADR_CFG = 8'h0C;
    localparam logic [7:0] ADR_PARAM = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    localparam logic [7:0] ADR_PEND_LO = 8'h18;
    localparam logic [7:0] ADR_PEND_HI = 8'h1C;
    localparam logic [7:0] ADR_EN_LO = 8'h20;
    localparam logic [7:0] ADR_EN_HI = 8'h24;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_INIT_BIT = 1;
    localparam int CTRL_GEN_BIT = 2;
    localparam int CMD_OP_LSB = 8;
    localparam int CFG_PRIO_LSB = 0;
    localparam int CFG_EDGE_BIT = 4;
    localparam int CFG_VALID_BIT = 8;
    localparam int CFG_SEQ_LSB = 16;
    localparam int STAT_DISP_LSB = 0;
    localparam int STAT_DISP_VLD_BIT = 6;
    localparam int STAT_RUN_LSB = 8;
    localparam int STAT_RUN_VLD_BIT = 14;
    localparam int STAT_SCAN_BIT = 15;
    localparam int STAT_INIT_BIT = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic RUN_RST = 1'b0;
    localparam logic GEN_RST = 1'b1;
    localparam logic [NUM_TASKS-1:0] EN_RST = '1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        TPS_ENABLE_ALL_TASKS,
        TPS_DISABLE_ALL_TASKS,
        TPS_ENABLE_SINGLE_TASK,
        TPS_DISABLE_SINGLE_TASK
    } tps_op_t;

    typedef struct packed {
        logic valid;
        logic falling;
        logic [2:0] prio;
        logic [5:0] seq;
    } tps_cfg_t;

    typedef struct packed {
        logic valid;
        logic [5:0] task_no;
    } tps_disp_t;

endpackage : tps_pkg

/* File: rtl/tps_fixed_timer.sv */
`timescale 1ns/1ps
module tps_fixed_timer
    import tps_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [CNT_W-1:0] period_i,
    // Request
    output logic req_o
);

    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Period store, zero keeps the timer idle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            period_r <= '0;
        else if (load_i)
            period_r <= period_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond count, one pulse per period
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
            req_o <= 1'b0;
        end
        else
        begin
            req_o <= 1'b0;
            if (load_i || period_r == '0)
                cnt_r <= '0;
            else if (tick_i)
            begin
                if (cnt_r + 32'h1 >= period_r)
                begin
                    cnt_r <= '0;
                    req_o <= 1'b1;
                end
                else
                    cnt_r <= cnt_r + 32'h1;
            end
        end
    end

endmodule : tps_fixed_timer

/* File: rtl/tps_scheduler.sv */
// Behaviour
// - Sixteen fixed cycle tasks, numbers 0 to 15
// - Eight external edge tasks, numbers 16 to 23
// - Sixteen internal condition tasks, numbers 24 to 39
// - Eight counter compare tasks, numbers 40 to 47
// - Fixed task once per millisecond-step period
// - External task on chosen input edge
// - Internal conditions checked only at scan end
// - Counter task when count equals compare value
// - Priority levels 2 to 7, 2 most urgent
// - Highest priority first, then arrival order
// - Simultaneous equal priority: earlier configured first
// - One execution per start condition occurrence
// - No task starts during initialization task
// - Scan runs only when no task active
// - Global enable and disable gate all starts
// - Single enable and disable gate one task
// - All tasks enabled after power-up
// - On completion, next task by priority
// - Request for pending or running task discarded
// - Period timers advance only in run mode
// - Higher priority preempts, preempted task resumes later
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tps_scheduler
    import tps_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter bit INIT_TASK_P = 1'b1
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Start sources
    input wire logic [NUM_EXT-1:0] EXT_IN_I,
    input wire logic [NUM_INT-1:0] INT_COND_I,
    input wire logic [NUM_HSC*CNT_W-1:0] HSC_COUNT_I,
    // Processor core
    input wire logic SCAN_END_I,
    input wire logic INIT_DONE_I,
    input wire logic CORE_START_I,
    input wire logic CORE_DONE_I,
    output logic DISP_VALID_O,
    output logic [5:0] DISP_TASK_O,
    output logic RUN_VALID_O,
    output logic [5:0] RUN_TASK_O,
    output logic SCAN_RUN_O,
    output logic INIT_RUN_O
);

    logic ack_r;
    logic [31:0] dat_r;
    logic [31:0] rd_data;
    logic wb_req;
    logic wr_en;
    logic run_r;
    logic init_r;
    logic gen_r;
    logic [NUM_TASKS-1:0] en_r;
    logic [5:0] sel_r;
    logic [5:0] seq_r;
    tps_cfg_t cfg_r [NUM_TASKS];
    logic [CNT_W-1:0] cmp_r [NUM_HSC];
    logic [NUM_HSC-1:0] match_r;
    logic [NUM_HSC-1:0] match_now;
    logic [31:0] ms_cnt_r;
    logic ms_tick;
    logic [NUM_EXT-1:0] ext_s1_r;
    logic [NUM_EXT-1:0] ext_s2_r;
    logic [NUM_EXT-1:0] ext_d_r;
    logic [NUM_FIX-1:0] fix_req;
    logic [NUM_EXT-1:0] ext_req;
    logic [NUM_INT-1:0] int_req;
    logic [NUM_HSC-1:0] hsc_req;
    logic [NUM_TASKS-1:0] req;
    logic [NUM_TASKS-1:0] pend_r;
    logic [NUM_TASKS-1:0] active_r;
    logic [NUM_TASKS-1:0] pend_set;
    logic [NUM_TASKS-1:0] start_mask;
    logic [NUM_TASKS-1:0] done_mask;
    logic [AGE_W-1:0] age_r [NUM_TASKS];
    logic best_found;
    logic [5:0] best_idx;
    logic [2:0] best_prio;
    logic [AGE_W-1:0] best_age;
    logic [5:0] best_seq;
    logic cur_found;
    logic [5:0] cur_idx;
    logic [2:0] cur_prio;
    tps_disp_t disp_r;
    logic start_ok;
    logic [5:0] cmd_no;
    logic [2:0] wr_prio;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign wb_req = CYC_I && STB_I;
    assign wr_en = wb_req && WE_I && !ack_r && (SEL_I == 4'hF);
    assign cmd_no = DAT_I[5:0];
    assign wr_prio = DAT_I[CFG_PRIO_LSB+:3];

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ack_r <= 1'b0;
            dat_r <= '0;
        end
        else
        begin
            ack_r <= wb_req && !ack_r;
            if (wb_req && !ack_r)
                dat_r <= rd_data;
        end
    end

    always_comb
    begin
        rd_data = '0;
        case (ADR_I)
            ADR_CTRL:
            begin
                rd_data[CTRL_RUN_BIT] = run_r;
                rd_data[CTRL_INIT_BIT] = init_r;
                rd_data[CTRL_GEN_BIT] = gen_r;
            end
            ADR_SEL: rd_data[5:0] = sel_r;
            ADR_CFG:
            begin
                rd_data[CFG_PRIO_LSB+:3] = cfg_r[sel_r].prio;
                rd_data[CFG_EDGE_BIT] = cfg_r[sel_r].falling;
                rd_data[CFG_VALID_BIT] = cfg_r[sel_r].valid;
                rd_data[CFG_SEQ_LSB+:6] = cfg_r[sel_r].seq;
            end
            ADR_PARAM:
                if (sel_r >= HSC_BASE && sel_r <= LAST_TASK)
                    rd_data = cmp_r[3'(sel_r - HSC_BASE)];
            ADR_STATUS:
            begin
                rd_data[STAT_DISP_LSB+:6] = disp_r.task_no;
                rd_data[STAT_DISP_VLD_BIT] = disp_r.valid;
                rd_data[STAT_RUN_LSB+:6] = RUN_TASK_O;
                rd_data[STAT_RUN_VLD_BIT] = RUN_VALID_O;
                rd_data[STAT_SCAN_BIT] = SCAN_RUN_O;
                rd_data[STAT_INIT_BIT] = init_r;
            end
            ADR_PEND_LO: rd_data = pend_r[31:0];
            ADR_PEND_HI: rd_data[15:0] = pend_r[47:32];
            ADR_EN_LO: rd_data = en_r[31:0];
            ADR_EN_HI: rd_data[15:0] = en_r[47:32];
            default: rd_data = '0;
        endcase
    end

    assign DAT_O = dat_r;
    assign ACK_O = ack_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control, commands and task configuration
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            run_r <= RUN_RST;
            gen_r <= GEN_RST;
            en_r <= EN_RST;
            sel_r <= '0;
        end
        else if (wr_en)
        begin
            case (ADR_I)
                ADR_CTRL: run_r <= DAT_I[CTRL_RUN_BIT];
                ADR_SEL: sel_r <= DAT_I[5:0];
                ADR_CMD:
                    case (tps_op_t'(DAT_I[CMD_OP_LSB+:2]))
                        TPS_ENABLE_ALL_TASKS: gen_r <= 1'b1;
                        TPS_DISABLE_ALL_TASKS: gen_r <= 1'b0;
                        TPS_ENABLE_SINGLE_TASK: if (cmd_no <= LAST_TASK) en_r[cmd_no] <= 1'b1;
                        TPS_DISABLE_SINGLE_TASK: if (cmd_no <= LAST_TASK) en_r[cmd_no] <= 1'b0;
                        default: gen_r <= gen_r;
                    endcase
                default: run_r <= run_r;
            endcase
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            seq_r <= '0;
            for (int i = 0; i < NUM_TASKS; i++)
                cfg_r[i] <= '{valid: 1'b0, falling: 1'b0, prio: PRIO_MAX, seq: 6'h3F};
        end
        else if (wr_en && ADR_I == ADR_CFG && sel_r <= LAST_TASK)
        begin
            cfg_r[sel_r].valid <= DAT_I[CFG_VALID_BIT];
            cfg_r[sel_r].falling <= DAT_I[CFG_EDGE_BIT];
            cfg_r[sel_r].prio <= (wr_prio < PRIO_MIN) ? PRIO_MIN : wr_prio;
            cfg_r[sel_r].seq <= seq_r;
            seq_r <= seq_r + 6'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond divider, halted outside run mode
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            ms_cnt_r <= '0;
        else if (!run_r)
            ms_cnt_r <= ms_cnt_r;
        else if (ms_tick)
            ms_cnt_r <= '0;
        else
            ms_cnt_r <= ms_cnt_r + 32'h1;
    end

    assign ms_tick = run_r && (ms_cnt_r == 32'(MS_CYCLES_P - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Start condition sources
    genvar g;
    generate
        for (g = 0; g < NUM_FIX; g++)
        begin : g_fix
            tps_fixed_timer u_timer (
                .clk_i(CLK_I),
                .rst_i(SYS_RST_I),
                .tick_i(ms_tick),
                .load_i(wr_en && ADR_I == ADR_PARAM && sel_r == 6'(g)),
                .period_i(DAT_I),
                .req_o(fix_req[g])
            );
        end
    endgenerate

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ext_s1_r <= '0;
            ext_s2_r <= '0;
            ext_d_r <= '0;
        end
        else
        begin
            ext_s1_r <= EXT_IN_I;
            ext_s2_r <= ext_s1_r;
            ext_d_r <= ext_s2_r;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            match_r <= '0;
            for (int k = 0; k < NUM_HSC; k++)
                cmp_r[k] <= '0;
        end
        else
        begin
            match_r <= match_now;
            for (int k = 0; k < NUM_HSC; k++)
                if (wr_en && ADR_I == ADR_PARAM && sel_r == HSC_BASE + 6'(k))
                    cmp_r[k] <= DAT_I;
        end
    end

    always_comb
    begin
        for (int k = 0; k < NUM_EXT; k++)
            ext_req[k] = cfg_r[EXT_BASE + 6'(k)].falling ? (ext_d_r[k] && !ext_s2_r[k])
                                                        : (!ext_d_r[k] && ext_s2_r[k]);
        for (int k = 0; k < NUM_HSC; k++)
            match_now[k] = HSC_COUNT_I[k*CNT_W+:CNT_W] == cmp_r[k];
    end

    assign hsc_req = match_now & ~match_r;
    assign int_req = SCAN_END_I ? INT_COND_I : '0;
    assign req = {hsc_req, int_req, ext_req, fix_req};

    ////////////////////////////////////////////////////////////////////////////
    // Pending and active task sets
    always_comb
    begin
        for (int i = 0; i < NUM_TASKS; i++)
            pend_set[i] = req[i] && cfg_r[i].valid && gen_r && en_r[i]
                          && !pend_r[i] && !active_r[i];
    end

    assign start_ok = disp_r.valid && CORE_START_I;
    assign start_mask = start_ok ? (48'h1 << disp_r.task_no) : '0;
    assign done_mask = (CORE_DONE_I && cur_found) ? (48'h1 << cur_idx) : '0;

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            pend_r <= '0;
            active_r <= '0;
        end
        else
        begin
            pend_r <= (pend_r & ~start_mask) | pend_set;
            active_r <= (active_r & ~done_mask) | start_mask;
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            for (int i = 0; i < NUM_TASKS; i++)
                age_r[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_TASKS; i++)
                if (pend_set[i])
                    age_r[i] <= '0;
                else if (pend_r[i] && age_r[i] != '1)
                    age_r[i] <= age_r[i] + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selection of the best pending task and the task now executing
    always_comb
    begin
        best_found = 1'b0;
        best_idx = '0;
        best_prio = PRIO_MAX;
        best_age = '0;
        best_seq = '1;
        cur_found = 1'b0;
        cur_idx = '0;
        cur_prio = PRIO_MAX;
        for (int i = 0; i < NUM_TASKS; i++)
        begin
            if (pend_r[i] && gen_r && en_r[i] && (!best_found || cfg_r[i].prio < best_prio
                || (cfg_r[i].prio == best_prio && (age_r[i] > best_age
                || (age_r[i] == best_age && cfg_r[i].seq < best_seq)))))
            begin
                best_found = 1'b1;
                best_idx = 6'(i);
                best_prio = cfg_r[i].prio;
                best_age = age_r[i];
                best_seq = cfg_r[i].seq;
            end
            if (active_r[i] && (!cur_found || cfg_r[i].prio < cur_prio))
            begin
                cur_found = 1'b1;
                cur_idx = 6'(i);
                cur_prio = cfg_r[i].prio;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dispatch offer to the core
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            disp_r <= '0;
        else if (start_ok)
            disp_r.valid <= 1'b0;
        else if (!disp_r.valid && best_found && !init_r
                 && (!cur_found || best_prio < cur_prio))
            disp_r <= '{valid: 1'b1, task_no: best_idx};
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            init_r <= INIT_TASK_P;
        else if (INIT_DONE_I)
            init_r <= 1'b0;
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            RUN_VALID_O <= 1'b0;
            RUN_TASK_O <= '0;
            SCAN_RUN_O <= 1'b0;
        end
        else
        begin
            RUN_VALID_O <= cur_found;
            RUN_TASK_O <= cur_idx;
            SCAN_RUN_O <= !init_r && !cur_found;
        end
    end

    assign DISP_VALID_O = disp_r.valid;
    assign DISP_TASK_O = disp_r.task_no;
    assign INIT_RUN_O = init_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_offer;
        disp_r.valid && !CORE_START_I;
    endsequence

    sequence s_taken;
        disp_r.valid && CORE_START_I;
    endsequence

    a_offer_holds: assert property (s_offer |=> disp_r.valid && $stable(disp_r.task_no))
        else $error("dispatch offer changed before start");
    a_start_clears: assert property (s_taken |=> !pend_r[$past(disp_r.task_no)]
                                     && active_r[$past(disp_r.task_no)])
        else $error("started task not moved from pending to active");
    a_init_blocks: assert property (init_r |=> !$rose(disp_r.valid))
        else $error("task offered during initialization");
    a_no_duplicate: assert property ((pend_r & active_r) == '0)
        else $error("task both pending and active");
    a_drop_disabled: assert property (!gen_r |=> (pend_r & ~$past(pend_r)) == '0)
        else $error("request latched while globally disabled");
    a_preempt_higher: assert property ($rose(disp_r.valid) |-> !$past(cur_found)
                                      || cfg_r[disp_r.task_no].prio < $past(cur_prio))
        else $error("offer does not outrank executing task");
    a_scan_yields: assert property (cur_found |=> !SCAN_RUN_O)
        else $error("scan shown running while a task is active");
    a_tick_spacing: assert property (ms_tick |-> ms_cnt_r == 32'(MS_CYCLES_P - 1) ##1 !ms_tick)
        else $error("millisecond tick misplaced");
    a_halt_timer: assert property (!run_r |-> !ms_tick ##1 $stable(ms_cnt_r))
        else $error("period time advanced outside run mode");
    a_prio_range: assert property (cfg_r[sel_r].prio >= PRIO_MIN)
        else $error("priority below most urgent level");

endmodule : tps_scheduler

/* File: dv/tps_core_model.sv */
`timescale 1ns/1ps
module tps_core_model
    import tps_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic hold_i,
    input wire logic init_ok_i,
    // Scheduler side
    input wire logic disp_valid_i,
    input wire logic run_valid_i,
    input wire logic scan_run_i,
    input wire logic init_run_i,
    output logic start_o,
    output logic done_o,
    output logic scan_end_o,
    output logic init_done_o
);
    logic [3:0] run_cnt_r;
    logic [3:0] scan_cnt_r;
    logic start_nxt;
    assign start_nxt = disp_valid_i & ~start_o & ~hold_i;
    ////////////////////////////////////////////////////////////
    // Start offered task, finish after fixed run time
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            start_o <= 1'b0;
            done_o <= 1'b0;
            run_cnt_r <= 4'h0;
        end
        else
        begin
            start_o <= start_nxt;
            done_o <= run_valid_i & (run_cnt_r == 4'h7) & ~start_nxt;
            run_cnt_r <= run_valid_i ? run_cnt_r + 4'h1 : 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////
    // Scan end and init completion
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scan_cnt_r <= 4'h0;
            scan_end_o <= 1'b0;
            init_done_o <= 1'b0;
        end
        else
        begin
            scan_cnt_r <= (scan_run_i & ~hold_i) ? scan_cnt_r + 4'h1 : 4'h0;
            scan_end_o <= (scan_cnt_r == 4'hF) & scan_run_i & ~hold_i;
            init_done_o <= init_ok_i & init_run_i & ~init_done_o;
        end
    end
endmodule : tps_core_model

/* File: dv/task_priority_scheduler_tb_top.sv */
`timescale 1ns/1ps
module task_priority_scheduler_tb_top
    import tps_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, hold, init_ok;
    logic [7:0] adr, ext;
    logic [3:0] sel, fl;
    logic [31:0] dat_w, dat_r, rd;
    logic [15:0] intc;
    logic [255:0] hsc;
    logic s_end, i_done, c_start, c_done, disp_v, run_v, scan_run, init_run;
    logic [5:0] disp_t, run_t;
    logic [5:0] started[$];
    logic [2:0] pr[4];
    int n_errors, checks, seed;

    tps_scheduler #(.MS_CYCLES_P(10)) i_dut (.CLK_I(clk), .SYS_RST_I(rst),
        .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w),
        .DAT_O(dat_r), .ACK_O(ack), .EXT_IN_I(ext), .INT_COND_I(intc), .HSC_COUNT_I(hsc),
        .SCAN_END_I(s_end), .INIT_DONE_I(i_done), .CORE_START_I(c_start), .CORE_DONE_I(c_done),
        .DISP_VALID_O(disp_v), .DISP_TASK_O(disp_t), .RUN_VALID_O(run_v), .RUN_TASK_O(run_t),
        .SCAN_RUN_O(scan_run), .INIT_RUN_O(init_run));
    tps_core_model i_core (.clk_i(clk), .rst_i(rst), .hold_i(hold), .init_ok_i(init_ok),
        .disp_valid_i(disp_v), .run_valid_i(run_v), .scan_run_i(scan_run), .init_run_i(init_run),
        .start_o(c_start), .done_o(c_done), .scan_end_o(s_end), .init_done_o(i_done));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
        if (c_start === 1'b1 && disp_v === 1'b1) started.push_back(disp_t);
    ////////////////////////////////////////////////////////////
    // Helpers
    task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task cfg(input logic [5:0] t, input logic [2:0] p, input logic f);
        wb(1'b1, ADR_SEL, {26'h0, t});
        wb(1'b1, ADR_CFG, {23'h0, 1'b1, 3'h0, f, 1'b0, p});
    endtask : cfg
    task cmd(input logic [1:0] op, input logic [5:0] t);
        wb(1'b1, ADR_CMD, {22'h0, op, 2'h0, t});
    endtask : cmd
    task pulse16();
        ext <= 8'h00;
        repeat (5) @(posedge clk);
        ext <= 8'h01;
        repeat (40) @(posedge clk);
    endtask : pulse16
    function automatic logic [5:0] nth(int k);
        int c;
        c = 0;
        for (int p = 2; p < 8; p++)
            for (int i = 0; i < 4; i++)
                if (pr[i] == p)
                begin
                    if (c == k) return 6'(16 + i);
                    c++;
                end
        return 6'h3F;
    endfunction : nth
    task wrap_up();
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        seed = 81;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0;
        ext = 8'h00;
        intc = 16'h0000;
        hsc = '0;
        hold = 1'b0;
        init_ok = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(rd[2:0], 3'h6, "ctrl");
        wb(1'b0, ADR_EN_LO, 32'h0);
        chk(rd, 32'hFFFFFFFF, "en_lo");
        wb(1'b0, ADR_EN_HI, 32'h0);
        chk(rd[15:0], 16'hFFFF, "en_hi");
        wb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0, "unmapped");
        cfg(6'h10, 3'h2, 1'b0);
        ext <= 8'h01;
        repeat (10) @(posedge clk);
        chk(disp_v, 1'b0, "disp_init");
        chk(init_run, 1'b1, "init_run");
        wb(1'b0, ADR_PEND_LO, 32'h0);
        chk(rd[16], 1'b1, "pend_init");
        init_ok <= 1'b1;
        repeat (40) @(posedge clk);
        chk(started.size(), 1, "n_init");
        chk(started[0], 6'h10, "task_ext");
        chk({scan_run, init_run}, 2'b10, "scan_idle");
        for (int r = 0; r < 3; r++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pr[i] = 3'(2 + {$random(seed)} % 6);
                fl[i] = 1'($random(seed));
                cfg(6'(16 + i), pr[i], fl[i]);
            end
            ext <= {4'h0, fl};
            repeat (100) @(posedge clk);
            hold <= 1'b1;
            started.delete();
            ext <= {4'h0, ~fl};
            repeat (10) @(posedge clk);
            hold <= 1'b0;
            repeat (200) @(posedge clk);
            chk(started.size(), 4, "n_order");
            for (int k = 0; k < 4; k++) chk(started[k], nth(k), "order");
        end
        cfg(6'h10, 3'h2, 1'b0);
        pulse16();
        started.delete();
        cmd(2'h3, 6'h10);
        pulse16();
        wb(1'b0, ADR_PEND_LO, 32'h0);
        chk(rd[16], 1'b0, "pend_off");
        wb(1'b0, ADR_EN_LO, 32'h0);
        chk(rd[16], 1'b0, "en_one");
        chk(started.size(), 0, "n_off");
        cmd(2'h2, 6'h10);
        pulse16();
        chk(started.size(), 1, "n_on");
        cmd(2'h1, 6'h00);
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(rd[2], 1'b0, "gen_off");
        pulse16();
        chk(started.size(), 1, "n_alloff");
        cmd(2'h0, 6'h00);
        pulse16();
        chk(started.size(), 2, "n_allon");
        hold <= 1'b1;
        pulse16();
        pulse16();
        hold <= 1'b0;
        repeat (8) @(posedge clk);
        chk({run_v, run_t, scan_run}, {1'b1, 6'h10, 1'b0}, "run");
        repeat (52) @(posedge clk);
        chk(started.size(), 3, "n_dup");
        cfg(6'h28, 3'h3, 1'b0);
        wb(1'b1, ADR_PARAM, 32'h00001234);
        hsc[31:0] <= 32'h00001233;
        ext <= 8'h00;
        repeat (5) @(posedge clk);
        started.delete();
        hsc[31:0] <= 32'h00001234;
        repeat (4) @(posedge clk);
        ext <= 8'h01;
        repeat (56) @(posedge clk);
        chk(started.size(), 2, "n_hsc");
        chk(started[0], 6'h28, "task_hsc");
        chk(started[1], 6'h10, "preempt");
        cfg(6'h18, 3'h5, 1'b0);
        hold <= 1'b1;
        @(posedge clk);
        intc <= 16'h0001;
        repeat (40) @(posedge clk);
        wb(1'b0, ADR_PEND_LO, 32'h0);
        chk(rd[24], 1'b0, "pend_int");
        hold <= 1'b0;
        repeat (80) @(posedge clk);
        chk(started[2], 6'h18, "task_int");
        intc <= 16'h0000;
        repeat (40) @(posedge clk);
        started.delete();
        cfg(6'h00, 3'h4, 1'b0);
        wb(1'b1, ADR_PARAM, 32'h3);
        repeat (200) @(posedge clk);
        chk(started.size(), 0, "n_stop");
        wb(1'b1, ADR_CTRL, 32'h1);
        repeat (300) @(posedge clk);
        wb(1'b1, ADR_CTRL, 32'h0);
        chk(32'(started.size() >= 9 && started.size() <= 11), 1, "n_fix");
        wrap_up();
    end
endmodule : task_priority_scheduler_tb_top
